/* core/cdq_channel.sv */
`timescale 1ns/1ps
`include "cdq_regs.svh"

module cdq_channel
	import cdq_pkg::*;
#(
	parameter int SLOTS = `CDQ_SLOTS
)
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Host order port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata_r,
	output logic             order_nak_r,
	// Channel program instructions
	input  wire logic        op_valid,
	input  wire cdq_op_e     op_code,
	output logic             op_done_r,
	// Data movement
	input  wire logic        dma_byte,
	input  wire logic [15:0] line_status,
	output cdq_addr_t        cur_addr_r,
	output logic      [15:0] cur_range_r,
	output logic             word_mode_r,
	output logic             last_char_r,
	// Indicators
	output logic             ind_zero_r,
	output logic      [3:0]  ind_ctrl_r,
	output logic      [7:0]  lct_ctrl_r,
	output logic             cur_valid_r,
	output logic             running_r,
	output logic             intr_a_r
);

	localparam int PW = $clog2(SLOTS);

	generate
		if (SLOTS < 2 || SLOTS > 8 || (1 << PW) != SLOTS)
		begin : g_bad_slots
			$error("SLOTS must be a power of two from 2 to 8");
		end
	endgenerate

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [PW-1:0] ring_add(input logic [PW-1:0] p, input logic [PW:0] n);
		ring_add = p + n[PW-1:0];
	endfunction

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
		hit = (a == ref_a);
	endfunction

	// ****************************************
	// Storage and state
	// ****************************************
	cdq_addr_t   mem_addr  [SLOTS];
	logic [15:0] mem_range [SLOTS];
	logic [7:0]  mem_ctrl  [SLOTS];
	logic [15:0] mem_stat  [SLOTS];

	logic [PW-1:0] top_r;
	logic [PW:0]   cnt_r;
	logic [PW:0]   given_r;
	logic [PW:0]   proc_r;
	cdq_addr_t     init_addr_r;
	logic [15:0]   init_range_r;
	logic [15:0]   resid_r;
	logic [15:0]   acc_r;
	cdq_addr_t     stage_addr_r;
	logic          ext_r;
	logic          rx_r;

	// ****************************************
	// Queue positions
	// ****************************************
	wire logic [PW:0]   one_c    = (PW+1)'(1);
	wire logic [PW:0]   has_n    = {{PW{1'b0}}, cur_valid_r};
	wire logic [PW-1:0] ph_idx   = ring_add(top_r, given_r);
	wire logic [PW-1:0] cur_idx  = ring_add(ph_idx, proc_r);
	wire logic [PW-1:0] nxt_idx  = ring_add(cur_idx, has_n);
	wire logic [PW-1:0] bot_idx  = ring_add(top_r, cnt_r);
	wire logic [PW-1:0] pout_idx = bot_idx - PW'(1);
	wire logic [PW-1:0] top2_idx = top_r + PW'(1);
	wire logic [PW:0]   next_n   = cnt_r - given_r - proc_r - has_n;
	wire logic [PW:0]   held_n   = proc_r + has_n + next_n;
	wire logic          full     = (cnt_r == (PW+1)'(SLOTS));
	wire logic          empty    = (cnt_r == '0);

	// ****************************************
	// Host order decode
	// ****************************************
	wire logic wr_range  = reg_wr && hit(reg_addr, `CDQ_A_LDA_RANGE);
	wire logic wr_ctrl   = reg_wr && hit(reg_addr, `CDQ_A_CTRL);
	wire logic wr_chan   = reg_wr && hit(reg_addr, `CDQ_A_CHAN_CTRL);
	wire logic rd_next   = reg_rd && hit(reg_addr, `CDQ_A_NEXT_STATUS);
	wire logic chan_stop = wr_chan && reg_wdata[`CDQ_CC_STOP];
	wire logic do_lda    = wr_range && !full;
	wire logic do_octl   = wr_ctrl && !empty;
	wire logic do_next   = rd_next && !empty && !op_valid;
	wire logic chan_ok   = wr_chan && !(chan_stop && op_valid);
	wire logic do_stop   = chan_ok && chan_stop;
	wire logic clr_list  = chan_ok && (reg_wdata[`CDQ_CC_LIST_RST] ||
		reg_wdata[`CDQ_CC_CHAN_INIT]);
	wire logic nak       = (wr_range && full) || (wr_ctrl && empty) ||
		(rd_next && !do_next) || (wr_chan && !chan_ok);

	// ****************************************
	// Channel program decode
	// ****************************************
	wire logic op_gnb   = op_valid && (op_code == CDQ_OP_GET_NEXT);
	wire logic op_rhb   = op_valid && (op_code == CDQ_OP_RETURN_HELD);
	wire logic op_cancel_char_op  = op_valid && (op_code == CDQ_OP_CANCEL_CHAR);
	wire logic op_cancel_block_op  = op_valid && (op_code == CDQ_OP_CANCEL_BLOCK);
	wire logic op_return_completed_op  = op_valid && (op_code == CDQ_OP_RETURN_DONE);
	wire logic return_completed_op_ok  = op_return_completed_op && ext_r && (proc_r != '0);
	wire logic complete = (op_gnb || do_stop) && cur_valid_r;
	wire logic fetch    = (op_gnb && next_n != '0) ||
		(op_rhb && held_n != '0);
	wire logic [PW-1:0] fetch_idx = op_rhb ? ph_idx : nxt_idx;
	wire logic at_start = (cur_addr_r == init_addr_r);
	wire logic move     = dma_byte && cur_valid_r && running_r;
	wire logic del_given = do_next && (given_r != '0);
	wire logic del_proc  = do_next && (given_r == '0) && (proc_r != '0);
	wire logic del_cur   = do_next && (given_r == '0) && (proc_r == '0) &&
		cur_valid_r && (top_r == cur_idx);

	// ****************************************
	// Read mux
	// ****************************************
	wire logic [31:0] rd_mux =
		hit(reg_addr, `CDQ_A_CTRL)        ? {24'h00_0000, mem_ctrl[top_r]} :
		hit(reg_addr, `CDQ_A_STATUS)      ? {16'h0000, mem_stat[top_r]} :
		hit(reg_addr, `CDQ_A_RANGE)       ? {16'h0000, mem_range[top_r]} :
		hit(reg_addr, `CDQ_A_NEXT_STATUS) ?
			(do_next ? {16'h0000, mem_stat[top2_idx]} : 32'h0000_0000) :
		hit(reg_addr, `CDQ_A_CONFIG)      ? {30'h0000_0000, rx_r, ext_r} :
		hit(reg_addr, `CDQ_A_LIST_STATE)  ?
			{8'h00, 4'h0, 4'(cnt_r), 4'(given_r), 4'(proc_r),
			2'h0, running_r, cur_valid_r, 4'(next_n)} :
		hit(reg_addr, `CDQ_A_CUR_ADDR)    ? {8'h00, cur_addr_r} :
		32'h0000_0000;

	// ****************************************
	// Bus answer and pulses
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reg_rdata_r <= 32'h0000_0000;
			order_nak_r <= 1'b0;
			op_done_r   <= 1'b0;
			intr_a_r    <= 1'b0;
		end
		else
		begin
			reg_rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
			order_nak_r <= nak;
			op_done_r   <= op_valid;
			intr_a_r    <= return_completed_op_ok && mem_ctrl[ph_idx][`CDQ_CTL_INT];
		end
	end

	// ****************************************
	// Configuration and run control
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ext_r        <= 1'b0;
			rx_r         <= 1'b0;
			running_r    <= 1'b0;
			stage_addr_r <= 24'h00_0000;
		end
		else
		begin
			if (reg_wr && hit(reg_addr, `CDQ_A_CONFIG))
			begin
				ext_r <= reg_wdata[`CDQ_CFG_EXT];
				rx_r  <= reg_wdata[`CDQ_CFG_RX];
			end
			if (reg_wr && hit(reg_addr, `CDQ_A_LDA_ADDR))
				stage_addr_r <= reg_wdata[23:0];
			if (chan_ok && reg_wdata[`CDQ_CC_START])
				running_r <= 1'b1;
			if (do_stop || (chan_ok && reg_wdata[`CDQ_CC_CHAN_INIT]))
				running_r <= 1'b0;
		end
	end

	// ****************************************
	// List pointers and queue counts
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || clr_list)
		begin
			top_r       <= '0;
			cnt_r       <= '0;
			given_r     <= '0;
			proc_r      <= '0;
			cur_valid_r <= 1'b0;
		end
		else
		begin
			if (do_lda)
				cnt_r <= cnt_r + one_c;
			if (do_next)
			begin
				top_r <= top2_idx;
				cnt_r <= cnt_r - one_c;
			end
			if (del_given || return_completed_op_ok)
				given_r <= del_given ? given_r - one_c : given_r + one_c;
			if (complete)
				proc_r <= proc_r + one_c;
			else if (op_rhb)
				proc_r <= '0;
			else if (return_completed_op_ok || del_proc)
				proc_r <= proc_r - one_c;
			if (op_gnb || op_rhb || do_stop || del_cur)
				cur_valid_r <= fetch;
		end
	end

	// ****************************************
	// Descriptor storage
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (do_lda)
		begin
			mem_addr[bot_idx]  <= stage_addr_r;
			mem_range[bot_idx] <= reg_wdata[15:0];
			mem_ctrl[bot_idx]  <= 8'h00;
			mem_stat[bot_idx]  <= 16'h0000;
		end
		if (do_octl)
		begin
			mem_ctrl[pout_idx] <= reg_wdata[7:0];
			mem_stat[pout_idx] <= 16'h0000;
		end
		if (complete)
		begin
			mem_stat[cur_idx] <= acc_r;
			if (!ext_r)
			begin
				mem_addr[cur_idx]  <= cur_addr_r;
				mem_range[cur_idx] <= cur_range_r;
			end
		end
		if (return_completed_op_ok)
		begin
			mem_stat[ph_idx]      <= mem_stat[ph_idx] | (16'h0001 << `CDQ_ST_COMPLETE);
			mem_ctrl[ph_idx][7:4] <= 4'h0;
			if (rx_r)
				mem_range[ph_idx] <= resid_r;
		end
	end

	// ****************************************
	// Status accumulation and residual
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || clr_list)
		begin
			acc_r   <= 16'h0000;
			resid_r <= 16'h0000;
		end
		else
		begin
			if (complete)
				acc_r <= (running_r && !do_stop) ? line_status : 16'h0000;
			else if (running_r)
				acc_r <= acc_r | line_status;
			if (complete && rx_r)
				resid_r <= cur_range_r;
		end
	end

	// ****************************************
	// Working address and range
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || clr_list)
		begin
			cur_addr_r   <= 24'h00_0000;
			cur_range_r  <= 16'h0000;
			init_addr_r  <= 24'h00_0000;
			init_range_r <= 16'h0000;
			last_char_r  <= 1'b0;
		end
		else if (fetch)
		begin
			cur_addr_r   <= mem_addr[fetch_idx];
			cur_range_r  <= mem_range[fetch_idx];
			init_addr_r  <= mem_addr[fetch_idx];
			init_range_r <= mem_range[fetch_idx];
			last_char_r  <= (mem_range[fetch_idx] == 16'h0000);
		end
		else if (op_cancel_block_op)
		begin
			cur_addr_r  <= init_addr_r;
			cur_range_r <= init_range_r;
			last_char_r <= (init_range_r == 16'h0000);
		end
		else if (op_cancel_char_op && !at_start)
		begin
			cur_addr_r  <= cur_addr_r - 24'h00_0001;
			cur_range_r <= cur_range_r + 16'h0001;
			last_char_r <= 1'b0;
		end
		else if (move && cur_range_r != 16'h0000)
		begin
			cur_addr_r  <= cur_addr_r + 24'h00_0001;
			cur_range_r <= cur_range_r - 16'h0001;
			last_char_r <= (cur_range_r == 16'h0001);
		end
	end

	// ****************************************
	// Transfer width
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst)
			word_mode_r <= 1'b0;
		else
			word_mode_r <= cur_valid_r && !cur_addr_r[0] &&
				(cur_range_r > 16'h0001);
	end

	// ****************************************
	// Indicators
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || clr_list)
		begin
			ind_zero_r <= 1'b0;
			ind_ctrl_r <= 4'h0;
			lct_ctrl_r <= 8'h00;
		end
		else
		begin
			if (fetch)
			begin
				ind_ctrl_r <= mem_ctrl[fetch_idx][7:4];
				lct_ctrl_r <= mem_ctrl[fetch_idx];
			end
			else if (op_gnb || op_rhb || do_stop || del_cur)
			begin
				ind_ctrl_r <= 4'h0;
				lct_ctrl_r <= 8'h00;
			end
			if (op_cancel_char_op)
				ind_zero_r <= at_start;
			else if (op_return_completed_op)
				ind_zero_r <= !return_completed_op_ok;
		end
	end

endmodule

/* pkg/cdq_regs.svh */
// Behaviour
// - Eight descriptor slots used as rotating ring
// - Descriptor: address, range, control, status fields
// - Control write clears descriptor status word
// - Completion copies accumulated line status word
// - Receive residual kept, written into range
// - Each byte: address up, range down, stop at zero
// - Word transfers, byte at odd start/end
// - Get-next: current to processed, fetch next
// - Extended mode keeps original address and range
// - Compatible mode writes final values, loads indicators
// - Return-held rewinds processed and current, refetches
// - Cancel-char steps back, zero at start
// - Cancel-block restores initial address and range
// - Return-completed (extended mode only) marks head processed, interrupts, advances
// - Return-completed on empty processed: zero only
// - Load adds at bottom; control targets it
// - Refuse load when eight already set up
// - Input-next deletes top; refused when empty
// - Input orders read top without removing
// - Resets empty list, restart at slot zero
// - Stop terminates current; start enables execution
// - Next, processed and current queues kept
// - Control interrupt bit requests completion interrupt
`ifndef CDQ_REGS_SVH
`define CDQ_REGS_SVH

`define CDQ_SLOTS         8
`define CDQ_A_LDA_ADDR    8'h00
`define CDQ_A_LDA_RANGE   8'h04
`define CDQ_A_CTRL        8'h08
`define CDQ_A_STATUS      8'h0C
`define CDQ_A_NEXT_STATUS 8'h10
`define CDQ_A_RANGE       8'h14
`define CDQ_A_CHAN_CTRL   8'h18
`define CDQ_A_CONFIG      8'h1C
`define CDQ_A_LIST_STATE  8'h20
`define CDQ_A_CUR_ADDR    8'h24
`define CDQ_CC_START      1
`define CDQ_CC_STOP       2
`define CDQ_CC_LIST_RST   3
`define CDQ_CC_CHAN_INIT  4
`define CDQ_CFG_EXT       0
`define CDQ_CFG_RX        1
`define CDQ_CTL_INT       7
`define CDQ_CTL_VALID     6
`define CDQ_CTL_LAST      5
`define CDQ_ST_COMPLETE   12

`endif

/* pkg/cdq_pkg.sv */
package cdq_pkg;

	typedef enum logic [2:0]
	{
		CDQ_OP_NONE         = 3'h0,
		CDQ_OP_GET_NEXT     = 3'h1,
		CDQ_OP_RETURN_HELD  = 3'h2,
		CDQ_OP_CANCEL_CHAR  = 3'h3,
		CDQ_OP_CANCEL_BLOCK = 3'h4,
		CDQ_OP_RETURN_DONE  = 3'h5
	} cdq_op_e;

	typedef logic [23:0] cdq_addr_t;

endpackage

/* dv/cdq_channel_assertions.sv */
`timescale 1ns/1ps
// ****************
// Port checker
// ****************
module cdq_channel_assertions
	import cdq_pkg::*;
(
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Host order port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata_r,
	input wire logic        order_nak_r,
	// Channel ops and data
	input wire logic        op_valid,
	input wire logic        op_done_r,
	input wire logic        dma_byte,
	input wire cdq_addr_t   cur_addr_r,
	input wire logic [15:0] cur_range_r,
	input wire logic        word_mode_r,
	input wire logic        last_char_r,
	input wire logic [3:0]  ind_ctrl_r,
	input wire logic [7:0]  lct_ctrl_r,
	input wire logic        cur_valid_r,
	input wire logic        running_r,
	input wire logic        intr_a_r
);
	wire step = cur_valid_r && running_r && dma_byte && !op_valid && !reg_wr && !reg_rd;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_nak_cause: assert property (order_nak_r |-> $past(reg_wr || reg_rd))
		else $error("Refusal without a host order");
	a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0000_0000)
		else $error("Read data outside its slot");
	a_op_done: assert property (op_valid |=> op_done_r)
		else $error("Op not acknowledged");
	a_done_cause: assert property (op_done_r |-> $past(op_valid))
		else $error("Op done without an op");
	a_intr_done: assert property (intr_a_r |-> op_done_r)
		else $error("Interrupt outside op completion");
	a_dma_step: assert property ((step && cur_range_r != 16'h0000) |=>
		(cur_addr_r == $past(cur_addr_r) + 24'h00_0001
		&& cur_range_r == $past(cur_range_r) - 16'h0001))
		else $error("Byte step wrong");
	a_range_frozen: assert property ((step && cur_range_r == 16'h0000) |=>
		($stable(cur_addr_r) && cur_range_r == 16'h0000))
		else $error("Moved at range zero");
	a_last_char: assert property ((step && cur_range_r == 16'h0001) |=> last_char_r)
		else $error("Last character not flagged");
	a_word_mode: assert property (word_mode_r ==
		$past(cur_valid_r && !cur_addr_r[0] && cur_range_r >= 16'h0002))
		else $error("Transfer width wrong");
	a_ctrl_view: assert property (ind_ctrl_r == lct_ctrl_r[7:4])
		else $error("Indicators differ from control byte");

	c_intr: cover property (intr_a_r);
	c_nak: cover property (order_nak_r);
	c_last: cover property ($rose(last_char_r));
endmodule

bind cdq_channel cdq_channel_assertions u_chk
(
	.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_r(reg_rdata_r), .order_nak_r(order_nak_r), .op_valid(op_valid),
	.op_done_r(op_done_r), .dma_byte(dma_byte), .cur_addr_r(cur_addr_r),
	.cur_range_r(cur_range_r), .word_mode_r(word_mode_r), .last_char_r(last_char_r),
	.ind_ctrl_r(ind_ctrl_r), .lct_ctrl_r(lct_ctrl_r), .cur_valid_r(cur_valid_r),
	.running_r(running_r), .intr_a_r(intr_a_r)
);

/* dv/cdq_host_model.sv */
`timescale 1ns/1ps
// ****************
// Host order model
// ****************
module cdq_host_model
(
	// Clock
	input  wire logic        clk,
	// Order bus
	output logic      [7:0]  reg_addr = 8'h00,
	output logic      [31:0] reg_wdata = 32'h0000_0000,
	output logic             reg_wr = 1'b0,
	output logic             reg_rd = 1'b0
);
	// One write order; lines inverted once released
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask

	// One read order
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
	endtask
endmodule

/* dv/cdq_channel_tb.sv */
`timescale 1ns/1ps
`include "cdq_regs.svh"
// ****************
// Channel bench
// ****************
module cdq_channel_tb
	import cdq_pkg::*;
;
	localparam logic [41:0] M_AR = 42'h0ff_ffff_ffff;
	localparam logic [41:0] M_I  = 42'h200_0000_0000;
	localparam logic [41:0] M_Z  = 42'h100_0000_0000;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic op_valid = 1'b0;
	cdq_op_e op_code = CDQ_OP_NONE;
	logic dma_byte = 1'b0;
	logic [15:0] line_status = 16'h0000;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata_r;
	logic reg_wr, reg_rd, order_nak_r, op_done_r, last_char_r, ind_zero_r, intr_a_r;
	logic [7:0] lct_ctrl_r;
	logic cur_valid_r, running_r;
	cdq_addr_t cur_addr_r, a0, a1;
	logic [15:0] cur_range_r, ls;
	logic stb_d = 1'b0;
	logic [64:0] rq[$];
	logic [83:0] oq[$];
	logic [64:0] rx;
	logic [83:0] ox;
	int err_count = 0;
	int total_checks = 0;

	always #12.5 clk = ~clk;

	cdq_host_model host
	(
		.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
	);

	cdq_channel DUT
	(
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .order_nak_r(order_nak_r),
		.op_valid(op_valid), .op_code(op_code), .op_done_r(op_done_r), .dma_byte(dma_byte),
		.line_status(line_status), .cur_addr_r(cur_addr_r), .cur_range_r(cur_range_r),
		.word_mode_r(), .last_char_r(last_char_r), .ind_zero_r(ind_zero_r), .ind_ctrl_r(),
		.lct_ctrl_r(lct_ctrl_r), .cur_valid_r(cur_valid_r), .running_r(running_r),
		.intr_a_r(intr_a_r)
	);

	task automatic chk(input string n, input logic [41:0] e, input logic [41:0] g);
		total_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic n);
		rq.push_back({n, 32'h0000_0000, 32'h0000_0000});
		host.wr(a, d);
	endtask

	task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic n);
		rq.push_back({n, m, e});
		host.rd(a);
	endtask

	task automatic load(input cdq_addr_t a, input logic [15:0] n, input logic [7:0] c);
		w(`CDQ_A_LDA_ADDR, {8'h00, a}, 1'b0);
		w(`CDQ_A_LDA_RANGE, {16'h0000, n}, 1'b0);
		w(`CDQ_A_CTRL, {24'h00_0000, c}, 1'b0);
	endtask

	task automatic op(input cdq_op_e c, input logic [41:0] e, input logic [41:0] m);
		oq.push_back({m, e});
		@(posedge clk);
		op_valid <= 1'b1;
		op_code  <= c;
		@(posedge clk);
		op_valid <= 1'b0;
	endtask

	task automatic dma(input int n);
		repeat (n) @(posedge clk) dma_byte <= 1'b1;
		@(posedge clk);
		dma_byte <= 1'b0;
	endtask

	// Result watcher: oldest note against each answer
	always @(posedge clk) stb_d <= reg_wr | reg_rd;
	always @(negedge clk)
	begin
		if (stb_d)
		begin
			rx = rq.pop_front();
			chk("nak", {41'h0, rx[64]}, {41'h0, order_nak_r});
			chk("rdata", {10'h000, rx[31:0] & rx[63:32]},
				{10'h000, reg_rdata_r & rx[63:32]});
		end
		if (op_done_r)
		begin
			ox = oq.pop_front();
			chk("op", ox[41:0] & ox[83:42],
				{intr_a_r, ind_zero_r, cur_addr_r, cur_range_r} & ox[83:42]);
		end
	end

	initial
	begin
		#(25 * 4000);
		err_count++;
		conclude();
	end

	initial
	begin
		void'($urandom(32'h0d65_8c26));
		a0 = {23'($urandom()), 1'b1};
		a1 = 24'($urandom());
		ls = 16'($urandom());
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		r(`CDQ_A_LIST_STATE, 32'h0000_0000, 32'hffff_ffff, 1'b0);
		w(`CDQ_A_CONFIG, 32'h0000_0001, 1'b0);
		w(`CDQ_A_CTRL, 32'h0000_00c0, 1'b1);
		load(a0, 16'h0003, 8'hc0);
		load(a1, 16'h0005, 8'h40);
		r(`CDQ_A_STATUS, 32'h0000_0000, 32'hffff_ffff, 1'b0);
		r(`CDQ_A_LIST_STATE, 32'h0002_0000, 32'h000f_0000, 1'b0);
		line_status <= ls;
		w(`CDQ_A_CHAN_CTRL, 32'h0000_0002, 1'b0);
		op(CDQ_OP_GET_NEXT, {2'b00, a0, 16'h0003}, M_AR | M_I);
		#1 chk("ctl", 42'h000_0000_03c0, {32'h0, running_r, cur_valid_r, lct_ctrl_r});
		dma(2);
		op(CDQ_OP_CANCEL_CHAR, {2'b00, a0 + 24'h00_0001, 16'h0002}, M_AR);
		op(CDQ_OP_CANCEL_BLOCK, {2'b00, a0, 16'h0003}, M_AR);
		op(CDQ_OP_CANCEL_CHAR, {2'b01, a0, 16'h0003}, M_AR | M_Z);
		op(CDQ_OP_RETURN_HELD, {2'b00, a0, 16'h0003}, M_AR);
		dma(5);
		#1 chk("dma", {2'b01, a0 + 24'h00_0003, 16'h0000},
			{1'b0, last_char_r, cur_addr_r, cur_range_r});
		op(CDQ_OP_GET_NEXT, {2'b00, a1, 16'h0005}, M_AR);
		op(CDQ_OP_RETURN_DONE, {2'b10, 40'h00_0000_0000}, M_I);
		op(CDQ_OP_RETURN_DONE, {2'b01, 40'h00_0000_0000}, M_I | M_Z);
		r(`CDQ_A_STATUS, {16'h0000, ls | 16'h1000}, 32'hffff_ffff, 1'b0);
		r(`CDQ_A_RANGE, 32'h0000_0003, 32'h0000_ffff, 1'b0);
		r(`CDQ_A_CTRL, 32'h0000_0000, 32'h0000_00f0, 1'b0);
		r(`CDQ_A_NEXT_STATUS, 32'h0000_0000, 32'hffff_ffff, 1'b0);
		r(`CDQ_A_NEXT_STATUS, 32'h0000_0000, 32'h0000_0000, 1'b0);
		r(`CDQ_A_NEXT_STATUS, 32'h0000_0000, 32'hffff_ffff, 1'b1);
		w(`CDQ_A_CHAN_CTRL, 32'h0000_0008, 1'b0);
		w(`CDQ_A_CTRL, 32'h0000_0040, 1'b1);
		repeat (8) load(24'($urandom()), 16'($urandom()), 8'h40);
		w(`CDQ_A_LDA_ADDR, $urandom() & 32'h00ff_ffff, 1'b0);
		w(`CDQ_A_LDA_RANGE, 32'h0000_0010, 1'b1);
		r(`CDQ_A_LIST_STATE, 32'h0008_0000, 32'h000f_0000, 1'b0);
		r(8'h40, 32'h0000_0000, 32'hffff_ffff, 1'b0);
		w(`CDQ_A_CHAN_CTRL, 32'h0000_0010, 1'b0);
		w(`CDQ_A_CONFIG, 32'h0000_0002, 1'b0);
		load(a1, 16'h0002, 8'h80);
		w(`CDQ_A_CHAN_CTRL, 32'h0000_0002, 1'b0);
		op(CDQ_OP_GET_NEXT, {2'b00, a1, 16'h0002}, M_AR);
		dma(1);
		w(`CDQ_A_CHAN_CTRL, 32'h0000_0004, 1'b0);
		r(`CDQ_A_RANGE, 32'h0000_0001, 32'h0000_ffff, 1'b0);
		r(`CDQ_A_LIST_STATE, 32'h0001_0100, 32'hffff_ffff, 1'b0);
		op(CDQ_OP_RETURN_DONE, {2'b01, 40'h00_0000_0000}, M_I | M_Z);
		wait (rq.size() == 0 && oq.size() == 0);
		repeat (2) @(posedge clk);
		conclude();
	end
endmodule
